//--- hdl/pcm_top.sv
// Clock control top: registers, standby sequencing and module clock gates
`timescale 1ns/10ps
`default_nettype none
module pcm_top #(
  parameter int AW          = 18,
  parameter int SETTLE_BASE = 16
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ext_clock_in,
  input  wire logic          standby_req,
  input  wire logic          wake_req,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               sys_clk_tick,
  output logic               clk_stopped,
  output logic [15:0]        module_clk_en,
  output logic [15:0]        ext_module_clk_en,
  output logic               all_clocks_stop
);
  typedef struct packed {
    logic [7:0]           standby_control;
    logic [7:0]           system_clock_control;
    logic [7:0]           pll_control;
    logic [15:0]          module_stop_pair;
    logic [15:0]          ext_module_stop_pair;
    logic [1:0]           mult_active;
    pcm_pkg::pcm_state_e  state;
    logic [19:0]          settle_cnt;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 sys_tick;
    logic [15:0]          mod_en;
    logic [15:0]          ext_en;
  } pcm_top_s;

  pcm_top_s  st;
  pcm_top_s  next_st;
  pcm_clk_if clk_bus ();

  logic        wr_go;
  logic        rd_go;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic [7:0]  wbyte;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_byte;
  logic        div_pick;
  logic [1:0]  new_mult;

  // Byte address to register index
  function automatic logic [15:0] addr_to_idx(input logic [AW-1:0] a);
    logic [AW-1:0] w;
    w = a >> 2;
    return w[15:0];
  endfunction

  // True where an index names a mapped register
  function automatic logic idx_mapped(input logic [15:0] idx);
    return (idx == pcm_pkg::IDX_STANDBY_CONTROL)
        || (idx == pcm_pkg::IDX_SYSTEM_CLOCK_CTRL)
        || (idx == pcm_pkg::IDX_MODULE_STOP_HIGH)
        || (idx == pcm_pkg::IDX_MODULE_STOP_LOW)
        || (idx == pcm_pkg::IDX_EXT_STOP_HIGH)
        || (idx == pcm_pkg::IDX_EXT_STOP_LOW)
        || (idx == pcm_pkg::IDX_PLL_CONTROL)
        || (idx == pcm_pkg::IDX_CLOCK_STATUS);
  endfunction

  // Settle cycles for a settle field value
  function automatic logic [19:0] settle_len(input logic [3:0] sel);
    logic [19:0] base;
    base = 20'(SETTLE_BASE);
    return base << sel;
  endfunction

  // Write and read handshakes: address and data taken together
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st.bvalid;
  assign rd_go = s_axi_arvalid & ~st.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_idx = addr_to_idx(s_axi_awaddr);
  assign rd_idx = addr_to_idx(s_axi_araddr);
  assign wbyte  = s_axi_wdata[7:0];
  assign wr_hit = idx_mapped(wr_idx);
  assign rd_hit = idx_mapped(rd_idx);

  // Read multiplexer, eight-bit data in the low lane
  always_comb begin
    unique case (rd_idx)
      pcm_pkg::IDX_STANDBY_CONTROL:   rd_byte = st.standby_control;
      pcm_pkg::IDX_SYSTEM_CLOCK_CTRL: rd_byte = st.system_clock_control;
      pcm_pkg::IDX_MODULE_STOP_HIGH:  rd_byte = st.module_stop_pair[15:8];
      pcm_pkg::IDX_MODULE_STOP_LOW:   rd_byte = st.module_stop_pair[7:0];
      pcm_pkg::IDX_EXT_STOP_HIGH:
        rd_byte = st.ext_module_stop_pair[15:8];
      pcm_pkg::IDX_EXT_STOP_LOW:
        rd_byte = st.ext_module_stop_pair[7:0];
      pcm_pkg::IDX_PLL_CONTROL:       rd_byte = st.pll_control;
      pcm_pkg::IDX_CLOCK_STATUS:
        rd_byte = {4'h0, st.state, st.mult_active};
      default:                        rd_byte = 8'h00;
    endcase
  end

  // Divided clock picked by the divider select field
  always_comb begin
    unique case (st.system_clock_control[pcm_pkg::DIV_SEL_MSB:0])
      pcm_pkg::DIV_2: div_pick = clk_bus.div_tick[0];
      pcm_pkg::DIV_4: div_pick = clk_bus.div_tick[1];
      pcm_pkg::DIV_8: div_pick = clk_bus.div_tick[2];
      default:        div_pick = clk_bus.pll_tick;
    endcase
    // Ticks still in the generator pipe must not leave once stopped
    if (!clk_bus.run) begin
      div_pick = 1'b0;
    end
  end

  // Next state: registers, standby sequence, clock gates
  always_comb begin
    next_st = st;
    new_mult = wbyte[pcm_pkg::MULT_SEL_MSB:0];
    // Register writes, low byte lane only
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_hit ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
      if (s_axi_wstrb[0]) begin
        unique case (wr_idx)
          pcm_pkg::IDX_STANDBY_CONTROL: next_st.standby_control = wbyte;
          pcm_pkg::IDX_SYSTEM_CLOCK_CTRL: begin
            next_st.system_clock_control = wbyte;
          end
          pcm_pkg::IDX_MODULE_STOP_HIGH: begin
            next_st.module_stop_pair[15:8] = wbyte;
          end
          pcm_pkg::IDX_MODULE_STOP_LOW: begin
            next_st.module_stop_pair[7:0] = wbyte;
          end
          pcm_pkg::IDX_EXT_STOP_HIGH: begin
            next_st.ext_module_stop_pair[15:8] = wbyte;
          end
          pcm_pkg::IDX_EXT_STOP_LOW: begin
            next_st.ext_module_stop_pair[7:0] = wbyte;
          end
          pcm_pkg::IDX_PLL_CONTROL: begin
            next_st.pll_control = wbyte;
            // Immediate switch mode applies a legal code at once
            if (st.system_clock_control[pcm_pkg::SWITCH_MODE_BIT]
                && new_mult != pcm_pkg::MULT_BAD) begin
              next_st.mult_active = new_mult;
            end
          end
          default: ;
        endcase
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read answer one cycle after the address is taken
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = rd_hit ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
      next_st.rdata  = {24'h000000, rd_byte};
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Software standby, load of the pending factor and settling
    unique case (st.state)
      pcm_pkg::PCM_RUN: begin
        if (standby_req && st.standby_control[pcm_pkg::STBY_ENABLE_BIT]) begin
          next_st.state = pcm_pkg::PCM_STANDBY;
        end
      end
      pcm_pkg::PCM_STANDBY: begin
        if (st.pll_control[pcm_pkg::MULT_SEL_MSB:0] != pcm_pkg::MULT_BAD) begin
          next_st.mult_active =
            st.pll_control[pcm_pkg::MULT_SEL_MSB:0];
        end
        if (wake_req) begin
          next_st.state = pcm_pkg::PCM_SETTLE;
          next_st.settle_cnt =
            settle_len(st.standby_control[pcm_pkg::SETTLE_MSB:0]);
        end
      end
      pcm_pkg::PCM_SETTLE: begin
        if (st.settle_cnt <= 20'h00001) begin
          next_st.state = pcm_pkg::PCM_RUN;
          next_st.settle_cnt = 20'h00000;
        end else begin
          next_st.settle_cnt = st.settle_cnt - 20'h00001;
        end
      end
      default: begin
        next_st.state = pcm_pkg::PCM_RUN;
      end
    endcase
    // Reserved extension bits are plain storage: they reset to ones
    // and keep what software writes; software is expected to write ones
    // back, so nothing forces them here
    // System tick and gated module clocks
    next_st.sys_tick = div_pick;
    for (int i = 0; i < 16; i++) begin
      next_st.mod_en[i] = div_pick & ~st.module_stop_pair[i];
      next_st.ext_en[i] = div_pick & ~st.ext_module_stop_pair[i];
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{standby_control:      pcm_pkg::RST_STANDBY_CONTROL,
              system_clock_control: pcm_pkg::RST_SYSTEM_CLOCK,
              pll_control:          pcm_pkg::RST_PLL_CONTROL,
              module_stop_pair:     pcm_pkg::RST_MODULE_STOP,
              ext_module_stop_pair: pcm_pkg::RST_EXT_STOP,
              mult_active:          pcm_pkg::MULT_X1,
              state:                pcm_pkg::PCM_RUN,
              default:              '0};
    end else begin
      st <= next_st;
    end
  end

  // Clock generator: runs except in standby and settling
  assign clk_bus.mult_active = st.mult_active;
  assign clk_bus.run = (st.state == pcm_pkg::PCM_RUN);

  pcm_clk_gen u_gen (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .ext_clock_in (ext_clock_in),
    .clk_port     (clk_bus.gen)
  );

  // Outputs
  assign s_axi_bvalid      = st.bvalid;
  assign s_axi_bresp       = st.bresp;
  assign s_axi_rvalid      = st.rvalid;
  assign s_axi_rresp       = st.rresp;
  assign s_axi_rdata       = st.rdata;
  assign sys_clk_tick      = st.sys_tick;
  assign clk_stopped       = (st.state != pcm_pkg::PCM_RUN);
  assign module_clk_en     = st.mod_en;
  assign ext_module_clk_en = st.ext_en;
  // All-clocks-stop needs every main and extension stop bit set
  assign all_clocks_stop = (st.module_stop_pair == pcm_pkg::RST_MODULE_STOP)
    && (st.ext_module_stop_pair == pcm_pkg::EXT_ALL_STOP);
endmodule
`default_nettype wire

//--- inc/pcm_pkg.sv
// Package of register map, field layout, reset values and states for pcm
package pcm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_STANDBY_CONTROL    = 16'hFF3A;
  localparam logic [15:0] IDX_SYSTEM_CLOCK_CTRL  = 16'hFF3B;
  localparam logic [15:0] IDX_MODULE_STOP_HIGH   = 16'hFF40;
  localparam logic [15:0] IDX_MODULE_STOP_LOW    = 16'hFF41;
  localparam logic [15:0] IDX_EXT_STOP_HIGH      = 16'hFF42;
  localparam logic [15:0] IDX_EXT_STOP_LOW       = 16'hFF43;
  localparam logic [15:0] IDX_PLL_CONTROL        = 16'hFF45;
  localparam logic [15:0] IDX_CLOCK_STATUS       = 16'hFF4F;

  // Field positions
  localparam int STBY_ENABLE_BIT   = 7;
  localparam int SETTLE_MSB        = 3;
  localparam int SWITCH_MODE_BIT   = 3;
  localparam int DIV_SEL_MSB       = 1;
  localparam int MULT_SEL_MSB      = 1;
  localparam int EXT_RSVD_LSB      = 12;

  // Reset values
  localparam logic [7:0]  RST_STANDBY_CONTROL = 8'h0F;
  localparam logic [7:0]  RST_SYSTEM_CLOCK    = 8'h00;
  localparam logic [7:0]  RST_PLL_CONTROL     = 8'h00;
  localparam logic [15:0] RST_MODULE_STOP     = 16'hFFFF;
  localparam logic [15:0] RST_EXT_STOP        = 16'hFFFF;
  localparam logic [15:0] EXT_ALL_STOP        = 16'hFFFF;
  localparam logic [3:0]  EXT_RSVD_ONES       = 4'hF;

  // Multiplier codes
  localparam logic [1:0] MULT_X1  = 2'h0;
  localparam logic [1:0] MULT_X2  = 2'h1;
  localparam logic [1:0] MULT_X4  = 2'h2;
  localparam logic [1:0] MULT_BAD = 2'h3;

  // Divider select codes
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator phase steps per fast cycle
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Power states, Gray coded along run, standby, settle
  typedef enum logic [1:0] {
    PCM_RUN     = 2'b00,
    PCM_STANDBY = 2'b01,
    PCM_SETTLE  = 2'b11
  } pcm_state_e;
endpackage

//--- inc/pcm_clk_if.sv
// Interface between the control core and the clock generator of pcm
`timescale 1ns/10ps
`default_nettype none
interface pcm_clk_if;
  logic [1:0] mult_active;
  logic       run;
  logic       pll_tick;
  logic [2:0] div_tick;

  modport ctl (output mult_active, output run,
               input pll_tick, input div_tick);
  modport gen (input mult_active, input run,
               output pll_tick, output div_tick);
endinterface
`default_nettype wire

//--- hdl/pcm_clk_gen.sv
// Phase-aligned clock multiplier and divider chain of pcm
`timescale 1ns/10ps
`default_nettype none
module pcm_clk_gen (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic ext_clock_in,
  pcm_clk_if.gen    clk_port
);
  typedef struct packed {
    logic       osc_prev;
    logic [1:0] phase;
    logic       pll_tick;
    logic [2:0] div_cnt;
    logic [2:0] div_tick;
  } pcm_gen_s;

  pcm_gen_s st;
  pcm_gen_s next_st;
  logic     osc_rise;
  logic     fire;

  // Multiplied tick, phase restarted on each oscillator rising edge
  always_comb begin
    next_st = st;
    osc_rise = ext_clock_in & ~st.osc_prev;
    next_st.osc_prev = ext_clock_in;
    next_st.phase = osc_rise ? 2'h1 : st.phase + 2'h1;
    unique case (clk_port.mult_active)
      pcm_pkg::MULT_X2: fire = osc_rise | (st.phase == 2'h2);
      pcm_pkg::MULT_X4: fire = 1'b1;
      default:          fire = osc_rise;
    endcase
    next_st.pll_tick = fire & clk_port.run;
    next_st.div_tick = 3'h0;
    // Divide the multiplied tick by 2, 4 and 8
    if (st.pll_tick) begin
      next_st.div_cnt = st.div_cnt + 3'h1;
      next_st.div_tick[0] = st.div_cnt[0];
      next_st.div_tick[1] = &st.div_cnt[1:0];
      next_st.div_tick[2] = &st.div_cnt[2:0];
    end
    if (!clk_port.run) begin
      next_st.div_cnt = 3'h0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_port.pll_tick = st.pll_tick;
  assign clk_port.div_tick = st.div_tick;
endmodule
`default_nettype wire

//--- test/pcm_top_sva.sv
// Port-level assertions for the clock control top
`timescale 1ns/10ps
`default_nettype none
module pcm_sva_chk (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        standby_req,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sys_clk_tick,
  input wire logic        clk_stopped,
  input wire logic [15:0] module_clk_en,
  input wire logic        all_clocks_stop
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Answers come one cycle after the take and stand until taken
  a_write_answer: assert property (s_axi_awready && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_stall: assert property (s_axi_bvalid
    |-> !s_axi_wready) else $error("write taken during answer");
  // Standby entry needs a request, and a stopped clock gives no ticks
  a_standby_cause: assert property ($rose(clk_stopped)
    |-> $past(standby_req)) else $error("standby without request");
  a_stopped_quiet: assert property (clk_stopped && $past(clk_stopped)
    |-> !sys_clk_tick) else $error("tick while stopped");
  // Main module gates only pass ticks, and all-stop shuts every main module gate
  a_gate_tick: assert property (module_clk_en != 16'h0000
    |-> sys_clk_tick) else $error("gate without tick");
  a_allstop_shut: assert property (all_clocks_stop [*3]
    |-> module_clk_en == 16'h0000) else $error("gate open in all-stop");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_standby: cover property ($rose(clk_stopped));
  c_resume: cover property ($fell(clk_stopped));
endmodule

bind pcm_top pcm_sva_chk u_pcm_sva_chk (.core_clk, .nrst, .standby_req,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .sys_clk_tick, .clk_stopped, .module_clk_en,
  .all_clocks_stop);
`default_nettype wire

//--- test/pcm_osc_model.sv
// Oscillator model: four core cycles to one period
`timescale 1ns/10ps
`default_nettype none
module pcm_osc_model (
  input  wire logic core_clk,
  output var logic  ext_clock_in
);
  logic [1:0] phase = 2'h0;
  initial ext_clock_in = 1'b0;
  // Free-running divider standing in for the crystal
  always @(posedge core_clk) begin
    phase <= phase + 2'h1;
    ext_clock_in <= phase[1];
  end
endmodule
`default_nettype wire

//--- test/tb_pcm_top.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`default_nettype none
module tb_pcm_top;
  logic        core_clk, nrst, ext_clock_in, standby_req, wake_req;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sys_clk_tick, clk_stopped;
  logic        all_clocks_stop;
  logic [15:0] module_clk_en, ext_module_clk_en;
  int          failures, checks, n_a, n_b;

  // Block with a short settle base
  pcm_top #(.AW(18), .SETTLE_BASE(1)) u_pcm_top (.core_clk, .nrst,
    .ext_clock_in, .standby_req, .wake_req, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_clk_tick,
    .clk_stopped, .module_clk_en, .ext_module_clk_en, .all_clocks_stop);
  pcm_osc_model u_pcm_osc_model (.core_clk, .ext_clock_in);

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Counts and verdict
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // A bounded wait ran out
  task automatic give_up;
    failures++;
    $display("BAD %0t wait ran out", $time);
    results;
  endtask

  // One register access; each channel stands until its own edge
  task automatic bus(input bit w, input logic [15:0] i,
                     input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_araddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'b1)
        break;
    end
    if (n == 50)
      give_up;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!w)
      chk(s_axi_rdata, d, "rdata");
    chk(32'(w ? s_axi_bresp : s_axi_rresp), 32'(r), "resp");
  endtask

  // Register write and read with an okay answer
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    bus(1'b1, i, d, 2'h0);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] d);
    bus(1'b0, i, d, 2'h0);
  endtask

  // Count ticks and gate pulses over 64 cycles once settled
  task automatic count(output int t, a, b, c);
    t = 0;
    a = 0;
    b = 0;
    c = 0;
    repeat (8) @(posedge core_clk);
    repeat (64) begin
      @(posedge core_clk);
      t += (sys_clk_tick === 1'b1);
      a += (module_clk_en[0] === 1'b1);
      b += (module_clk_en[1] === 1'b1);
      c += (ext_module_clk_en[1] === 1'b1);
    end
  endtask

  // Reset values, byte lane and unmapped index
  task automatic t_reset;
    rd(16'hFF3A, 32'h0F);
    rd(16'hFF3B, 32'h00);
    rd(16'hFF45, 32'h00);
    rd(16'hFF40, 32'hFF);
    rd(16'hFF41, 32'hFF);
    rd(16'hFF42, 32'hFF);
    rd(16'hFF43, 32'hFF);
    rd(16'hFF4F, 32'h00);
    bus(1'b0, 16'hFF44, 32'h0, 2'h2);
    bus(1'b1, 16'hFF44, 32'h1, 2'h2);
    wr(16'hFF41, 32'h00);
    rd(16'hFF41, 32'h00);
    wr(16'hFF41, 32'hFF);
    wr(16'hFF40, 32'h123456C3);
    rd(16'hFF40, 32'hC3);
    wr(16'hFF40, 32'hFF);
  endtask

  // Immediate switching over every factor, then every divider at x4
  task automatic t_rates;
    int t, a, b, c, k;
    wr(16'hFF3B, 32'h08);
    for (k = 0; k < 3; k++) begin
      wr(16'hFF45, k);
      rd(16'hFF4F, k);
      count(t, a, b, c);
      chk(t, 16 << k, "factor ticks");
    end
    // The unused factor code leaves the active factor alone
    wr(16'hFF45, 32'h03);
    rd(16'hFF4F, 32'h02);
    for (k = 1; k < 4; k++) begin
      wr(16'hFF3B, 8 + k);
      count(t, a, b, c);
      chk(t, 64 >> k, "divided ticks");
    end
  endtask

  // Standby request while standby is disabled
  task automatic t_refused;
    wr(16'hFF3A, 32'h03);
    standby_req <= 1'b1;
    @(posedge core_clk);
    standby_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'(clk_stopped), 32'h0, "refused standby");
  endtask

  // Deferred switch through standby with settle field s, code m
  task automatic t_standby(input int s, m, old, output int cyc);
    int t, a, b, c;
    wr(16'hFF3B, 32'h00);
    wr(16'hFF3A, 8'h80 + s);
    wr(16'hFF45, m);
    count(t, a, b, c);
    chk(t, 16 << old, "deferred ticks");
    standby_req <= 1'b1;
    @(posedge core_clk);
    standby_req <= 1'b0;
    @(posedge core_clk);
    chk(32'(clk_stopped), 32'h1, "stopped");
    rd(16'hFF4F, 4 + m);
    wake_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    for (cyc = 0; cyc < 500; cyc++) begin
      @(posedge core_clk);
      if (clk_stopped === 1'b0)
        break;
    end
    if (cyc == 500)
      give_up;
    count(t, a, b, c);
    chk(t, 16 << m, "resumed ticks");
  endtask

  // Module gates, extension pair and all-stop at x4 undivided
  task automatic t_gating;
    int t, a, b, c;
    wr(16'hFF41, 32'hFE);
    wr(16'hFF42, 32'hF0);
    rd(16'hFF42, 32'hF0);
    wr(16'hFF42, 32'hFF);
    wr(16'hFF43, 32'hFD);
    chk(32'(all_clocks_stop), 32'h0, "all stop low");
    count(t, a, b, c);
    chk(a, 64, "gate open");
    chk(b, 0, "gate shut");
    chk(c, 64, "ext gate open");
    wr(16'hFF41, 32'hFF);
    wr(16'hFF43, 32'hFF);
    chk(32'(all_clocks_stop), 32'h1, "all stop high");
    count(t, a, b, c);
    chk(a + c, 0, "gates shut");
    wr(16'hFF43, 32'hFD);
    chk(32'(all_clocks_stop), 32'h0, "ext joins all stop");
  endtask

  // Reset again in mid-run: registers and factor fall back
  task automatic t_rereset;
    int t, a, b, c;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(16'hFF4F, 32'h00);
    rd(16'hFF45, 32'h00);
    rd(16'hFF43, 32'hFF);
    count(t, a, b, c);
    chk(t, 16, "factor after reset");
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    standby_req = 1'b0;
    wake_req = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset;
    t_rates;
    t_refused;
    t_standby(2, 1, 2, n_a);
    t_standby(3, 2, 1, n_b);
    chk(n_b - n_a, 4, "settle growth");
    t_gating;
    t_rereset;
    results;
  end
endmodule
`default_nettype wire
